// [vrrb_register_bank.sv]
// Register bank for the upper register map of a multi-rail regulator controller
`include "vrrb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module vrrb_register_bank #(
    parameter bit POWER_DOMAIN = 1'b0,
    parameter bit TWO_PHASE = 1'b1,
    parameter int READY_CYCLES = `VRRB_READY_CYC
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Controller enable and startup inputs
    input wire logic ENABLE,
    input wire logic [7:0] BOOT_CODE,
    input wire logic [7:0] PLATFORM_MAX_CURRENT,
    input wire logic [7:0] TEMPERATURE,
    // Register access from the frame decoder
    input wire vrrb_pkg::vrrb_req_t REQ,
    output logic [7:0] RDATA,
    output logic RVALID,
    // Voltage-set commands
    input wire vrrb_pkg::vrrb_vcmd_t VCMD,
    output vrrb_pkg::vrrb_ack_t ACK,
    // Regulation outputs
    output logic [7:0] TARGET_CODE,
    output logic [7:0] SLOW_RAMP_RATE,
    output logic OVERTEMPERATURE_ALERT,
    output logic READY
);

    // Registered and next state
    vrrb_pkg::vrrb_state_t st;
    vrrb_pkg::vrrb_state_t next_st;

    // Slow rate from fast rate and one-hot selector
    function automatic logic [7:0] slow_rate(input logic [7:0] sel);
        logic [7:0] fast;
        fast = `VRRB_RST_FAST_SLEW;
        case (sel)
            `VRRB_SEL_DIV4: slow_rate = fast >> 2;
            `VRRB_SEL_DIV8: slow_rate = fast >> 3;
            `VRRB_SEL_DIV16: slow_rate = fast >> 4;
            default: slow_rate = fast >> 1;
        endcase
    endfunction : slow_rate

    // Whether an offset exists in the current domain
    function automatic logic present(input logic [7:0] a);
        if (POWER_DOMAIN) begin
            present = (a == `VRRB_OFS_PIN_SCALE);
        end else begin
            present = (a != `VRRB_OFS_PIN_SCALE);
        end
    endfunction : present

    // Code plus signed margin, clamped to 0..255
    function automatic logic [7:0] add_margin(input logic [7:0] c, input logic [7:0] m);
        logic signed [9:0] s;
        s = $signed({2'b00, c}) + $signed({{2{m[7]}}, m});
        if (s < 0) begin
            add_margin = 8'h00;
        end else if (s > 10'sd255) begin
            add_margin = 8'hFF;
        end else begin
            add_margin = s[7:0];
        end
    endfunction : add_margin

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.ack = vrrb_pkg::VRRB_ACK_NONE;
        // Startup sequence
        case (st.phase)
            vrrb_pkg::VRRB_ST_OFF: begin
                if (ENABLE) begin
                    next_st.phase = vrrb_pkg::VRRB_ST_WAIT;
                    next_st.wait_cnt = 32'h0000_0000;
                end
            end
            vrrb_pkg::VRRB_ST_WAIT: begin
                if (st.wait_cnt >= READY_CYCLES - 1) begin
                    next_st.phase = vrrb_pkg::VRRB_ST_READY;
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 32'h0000_0001;
                end
            end
            vrrb_pkg::VRRB_ST_READY: begin
                if (!ENABLE) begin
                    next_st.phase = vrrb_pkg::VRRB_ST_OFF;
                end
            end
            default: begin
                next_st.phase = vrrb_pkg::VRRB_ST_OFF;
            end
        endcase
        next_st.ready = (next_st.phase == vrrb_pkg::VRRB_ST_READY);
        if (st.phase == vrrb_pkg::VRRB_ST_OFF && ENABLE && !st.boot_taken) begin
            next_st.boot_volt = BOOT_CODE;
            next_st.boot_taken = 1'b1;
        end
        if (st.phase == vrrb_pkg::VRRB_ST_OFF && ENABLE && !st.boot_taken) begin
            next_st.lim1 = TWO_PHASE ? (PLATFORM_MAX_CURRENT >> 1) : PLATFORM_MAX_CURRENT;
            next_st.lim2 = TWO_PHASE
                ? 8'((16'(PLATFORM_MAX_CURRENT) * 16'h0003) / 16'h000A)
                : 8'((16'(PLATFORM_MAX_CURRENT) * 16'h0005) >> 3);
        end

        // Register write, only when ready
        if (REQ.wr && st.ready && present(REQ.addr)) begin
            case (REQ.addr)
                `VRRB_OFS_TEMP_LIMIT: begin
                    next_st.temp_limit = REQ.wdata;
                end
                `VRRB_OFS_SLOW_SEL: begin
                    if (REQ.wdata == `VRRB_SEL_DIV2 || REQ.wdata == `VRRB_SEL_DIV4
                        || REQ.wdata == `VRRB_SEL_DIV8 || REQ.wdata == `VRRB_SEL_DIV16) begin
                        next_st.slow_sel = REQ.wdata;
                    end
                end
                `VRRB_OFS_PIN_SCALE: begin
                    next_st.pin_scale = REQ.wdata;
                end
                `VRRB_OFS_MAX_CODE: begin
                    next_st.max_code = REQ.wdata;
                end
                `VRRB_OFS_VCODE: begin
                    next_st.vcode = REQ.wdata;
                end
                `VRRB_OFS_PSTATE: begin
                    next_st.pstate = REQ.wdata;
                end
                `VRRB_OFS_MARGIN: begin
                    next_st.margin = REQ.wdata;
                end
                // Multi-regulator configuration, stored only
                `VRRB_OFS_MULTI_CFG: begin
                    next_st.multi_cfg = REQ.wdata;
                end
                // First limit voltage code
                `VRRB_OFS_LIM1_CODE: begin
                    next_st.lim1_code = REQ.wdata;
                end
                `VRRB_OFS_LIM1: begin
                    next_st.lim1 = REQ.wdata;
                end
                // Second limit voltage code
                `VRRB_OFS_LIM2_CODE: begin
                    next_st.lim2_code = REQ.wdata;
                end
                `VRRB_OFS_LIM2: begin
                    next_st.lim2 = REQ.wdata;
                end
                // Third limit voltage code
                `VRRB_OFS_LIM3_CODE: begin
                    next_st.lim3_code = REQ.wdata;
                end
                `VRRB_OFS_COND_THR: begin
                    next_st.cond_thr = REQ.wdata;
                end
                default: begin
                    // Contents left as they are
                end
            endcase
        end

        // Register read, one cycle later
        if (REQ.rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = 8'h00;
            if (present(REQ.addr)) begin
                case (REQ.addr)
                    // Temperature limit readback
                    `VRRB_OFS_TEMP_LIMIT: begin
                        next_st.rdata = st.temp_limit;
                    end
                    `VRRB_OFS_FAST_SLEW: begin
                        next_st.rdata = `VRRB_RST_FAST_SLEW;
                    end
                    `VRRB_OFS_SLOW_SLEW: begin
                        next_st.rdata = slow_rate(st.slow_sel);
                    end
                    // Boot code caught at enable
                    `VRRB_OFS_BOOT_VOLT: begin
                        next_st.rdata = st.boot_volt;
                    end
                    // Divisor selector readback
                    `VRRB_OFS_SLOW_SEL: begin
                        next_st.rdata = st.slow_sel;
                    end
                    `VRRB_OFS_DEEP_LAT: begin
                        next_st.rdata = `VRRB_RST_DEEP_LAT;
                    end
                    `VRRB_OFS_LIGHT_LAT: begin
                        next_st.rdata = `VRRB_RST_LIGHT_LAT;
                    end
                    `VRRB_OFS_READY_LAT: begin
                        next_st.rdata = `VRRB_RST_READY_LAT;
                    end
                    // Input power scaling readback
                    `VRRB_OFS_PIN_SCALE: begin
                        next_st.rdata = st.pin_scale;
                    end
                    // Maximum code readback
                    `VRRB_OFS_MAX_CODE: begin
                        next_st.rdata = st.max_code;
                    end
                    // Programmed voltage code
                    `VRRB_OFS_VCODE: begin
                        next_st.rdata = st.vcode;
                    end
                    // Programmed power state
                    `VRRB_OFS_PSTATE: begin
                        next_st.rdata = st.pstate;
                    end
                    // Margin offset readback
                    `VRRB_OFS_MARGIN: begin
                        next_st.rdata = st.margin;
                    end
                    // Multi-regulator configuration
                    `VRRB_OFS_MULTI_CFG: begin
                        next_st.rdata = st.multi_cfg;
                    end
                    // First limit voltage code
                    `VRRB_OFS_LIM1_CODE: begin
                        next_st.rdata = st.lim1_code;
                    end
                    // First current limit
                    `VRRB_OFS_LIM1: begin
                        next_st.rdata = st.lim1;
                    end
                    // Second limit voltage code
                    `VRRB_OFS_LIM2_CODE: begin
                        next_st.rdata = st.lim2_code;
                    end
                    // Second current limit
                    `VRRB_OFS_LIM2: begin
                        next_st.rdata = st.lim2;
                    end
                    // Third limit voltage code
                    `VRRB_OFS_LIM3_CODE: begin
                        next_st.rdata = st.lim3_code;
                    end
                    // Conduction threshold readback
                    `VRRB_OFS_COND_THR: begin
                        next_st.rdata = st.cond_thr;
                    end
                    // Unmapped offset
                    default: begin
                        next_st.rdata = 8'h00;
                    end
                endcase
            end
        end

        // Voltage-set command handling
        if (VCMD.valid) begin
            if (!st.ready || POWER_DOMAIN) begin
                // Not ready or no rail here
                next_st.ack = vrrb_pkg::VRRB_ACK_REJECT;
            end else if (VCMD.code > st.max_code) begin
                next_st.ack = vrrb_pkg::VRRB_ACK_UNSUPPORTED;
            end else begin
                next_st.ack = vrrb_pkg::VRRB_ACK_OK;
                next_st.vcode = VCMD.code;
            end
        end
        if (next_st.vcode == 8'h00) begin
            next_st.target = next_st.boot_volt;
        end else begin
            next_st.target = add_margin(next_st.vcode, next_st.margin);
        end
        next_st.hot = !POWER_DOMAIN && (TEMPERATURE >= st.temp_limit);

        // Slow rate kept in a flop for the pin
        next_st.ramp_slow = slow_rate(next_st.slow_sel);
    end

    // State register
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            // Everything else clears to zero
            st <= '0;
            // Startup begins switched off
            st.phase <= vrrb_pkg::VRRB_ST_OFF;
            // No acknowledge pending
            st.ack <= vrrb_pkg::VRRB_ACK_NONE;
            // Alert level at 100 degrees
            st.temp_limit <= `VRRB_RST_TEMP_LIMIT;
            // Divide-by-two selected
            st.slow_sel <= `VRRB_RST_SLOW_SEL;
            // Matching slow rate on the pin
            st.ramp_slow <= `VRRB_RST_SLOW_SLEW;
            // Scaling at full range
            st.pin_scale <= `VRRB_RST_PIN_SCALE;
            // Highest accepted code
            st.max_code <= `VRRB_RST_MAX_CODE;
            // Multi-regulator configuration
            st.multi_cfg <= `VRRB_RST_MULTI_CFG;
            // Conduction threshold
            st.cond_thr <= `VRRB_RST_COND_THR;
        end else begin
            // Take the computed next state
            st <= next_st;
        end
    end

    // Outputs straight from state
    // Read data, held until the next read
    assign RDATA = st.rdata;
    // One-cycle read answer
    assign RVALID = st.rvalid;
    // One-cycle command acknowledge
    assign ACK = st.ack;
    // Regulated code with margin, or the boot code while vcode is zero
    assign TARGET_CODE = st.target;
    // Slow rate, registered
    assign SLOW_RAMP_RATE = st.ramp_slow;
    // Over-temperature level
    assign OVERTEMPERATURE_ALERT = st.hot;
    // Register writes and voltage commands accepted; reads are answered at any time
    assign READY = st.ready;

endmodule : vrrb_register_bank
`default_nettype wire

// [vrrb_consts.svh]
// Register offsets, reset values and timing figures of the voltage-regulator register bank
`ifndef VRRB_CONSTS_SVH
`define VRRB_CONSTS_SVH
`define VRRB_OFS_TEMP_LIMIT 8'h22
`define VRRB_OFS_FAST_SLEW 8'h24
`define VRRB_OFS_SLOW_SLEW 8'h25
`define VRRB_OFS_BOOT_VOLT 8'h26
`define VRRB_OFS_SLOW_SEL 8'h2A
`define VRRB_OFS_DEEP_LAT 8'h2B
`define VRRB_OFS_LIGHT_LAT 8'h2C
`define VRRB_OFS_READY_LAT 8'h2D
`define VRRB_OFS_PIN_SCALE 8'h2E
`define VRRB_OFS_MAX_CODE 8'h30
`define VRRB_OFS_VCODE 8'h31
`define VRRB_OFS_PSTATE 8'h32
`define VRRB_OFS_MARGIN 8'h33
`define VRRB_OFS_MULTI_CFG 8'h34
`define VRRB_OFS_LIM1_CODE 8'h42
`define VRRB_OFS_LIM1 8'h43
`define VRRB_OFS_LIM2_CODE 8'h44
`define VRRB_OFS_LIM2 8'h45
`define VRRB_OFS_LIM3_CODE 8'h46
`define VRRB_OFS_COND_THR 8'h47
`define VRRB_RST_TEMP_LIMIT 8'h64
`define VRRB_RST_FAST_SLEW 8'h1E
`define VRRB_RST_SLOW_SLEW 8'h0F
`define VRRB_RST_SLOW_SEL 8'h01
`define VRRB_RST_DEEP_LAT 8'h8C
`define VRRB_RST_LIGHT_LAT 8'h55
`define VRRB_RST_READY_LAT 8'hCA
`define VRRB_RST_PIN_SCALE 8'hFF
`define VRRB_RST_MAX_CODE 8'hFB
`define VRRB_RST_MULTI_CFG 8'h01
`define VRRB_RST_COND_THR 8'h03
`define VRRB_SEL_DIV2 8'h01
`define VRRB_SEL_DIV4 8'h02
`define VRRB_SEL_DIV8 8'h04
`define VRRB_SEL_DIV16 8'h08
// Enable-to-ready wait, microseconds, and clock rate in MHz
`define VRRB_READY_US 202
`define VRRB_CLK_MHZ 20
`define VRRB_READY_CYC (`VRRB_READY_US * `VRRB_CLK_MHZ)
`endif

// [vrrb_pkg.sv]
// Types shared by the voltage-regulator register bank
package vrrb_pkg;
    // Bus request from the serial frame decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vrrb_req_t;
    // Voltage-set command from the frame decoder
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } vrrb_vcmd_t;
    // Acknowledge codes
    typedef enum logic [1:0] {
        VRRB_ACK_NONE,
        VRRB_ACK_OK,
        VRRB_ACK_REJECT,
        VRRB_ACK_UNSUPPORTED
    } vrrb_ack_t;
    // Startup sequence
    typedef enum logic [1:0] {
        VRRB_ST_OFF,
        VRRB_ST_WAIT,
        VRRB_ST_READY
    } vrrb_phase_t;
    // All state of the bank
    typedef struct packed {
        vrrb_phase_t phase;
        logic [31:0] wait_cnt;
        logic [7:0] temp_limit;
        logic [7:0] slow_sel;
        logic [7:0] boot_volt;
        logic [7:0] pin_scale;
        logic [7:0] max_code;
        logic [7:0] vcode;
        logic [7:0] pstate;
        logic [7:0] margin;
        logic [7:0] multi_cfg;
        logic [7:0] lim1_code;
        logic [7:0] lim1;
        logic [7:0] lim2_code;
        logic [7:0] lim2;
        logic [7:0] lim3_code;
        logic [7:0] cond_thr;
        logic [7:0] rdata;
        logic rvalid;
        vrrb_ack_t ack;
        logic hot;
        logic [7:0] ramp_slow;
        logic [7:0] target;
        logic boot_taken;
        logic ready;
    } vrrb_state_t;
endpackage : vrrb_pkg

// [vrrb_bank_sva.sv]
// Port assertions for the voltage-regulator register bank
`timescale 1ns/1ps
`default_nettype none
module vrrb_bank_sva (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Watched ports
    input wire logic ENABLE,
    input wire vrrb_pkg::vrrb_req_t REQ,
    input wire logic RVALID,
    input wire vrrb_pkg::vrrb_vcmd_t VCMD,
    input wire vrrb_pkg::vrrb_ack_t ACK,
    input wire logic [7:0] SLOW_RAMP_RATE,
    input wire logic READY
);
    // Single domain for every property
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_read_answer: assert property (REQ.rd |=> RVALID)
        else $error("read got no answer");
    a_read_idle: assert property (!REQ.rd |=> !RVALID)
        else $error("read answer without request");
    a_ack_follows: assert property (VCMD.valid |=> ACK != vrrb_pkg::VRRB_ACK_NONE)
        else $error("voltage command not acknowledged");
    a_ack_idle: assert property (!VCMD.valid |=> ACK == vrrb_pkg::VRRB_ACK_NONE)
        else $error("acknowledge without command");
    a_early_reject: assert property (VCMD.valid && !READY |=> ACK == vrrb_pkg::VRRB_ACK_REJECT)
        else $error("command accepted before ready");
    a_ok_ready: assert property (ACK == vrrb_pkg::VRRB_ACK_OK |-> $past(READY))
        else $error("ok acknowledge while not ready");
    a_ready_enable: assert property ($rose(READY) |-> ENABLE && $past(ENABLE, 4))
        else $error("ready rose without enable");
    a_slow_legal: assert property (SLOW_RAMP_RATE inside {8'h0f, 8'h07, 8'h03, 8'h01})
        else $error("slow ramp rate not a legal division");
    // Main scenarios reached
    c_read: cover property (RVALID);
    c_unsupported: cover property (ACK == vrrb_pkg::VRRB_ACK_UNSUPPORTED);
    c_ready: cover property ($rose(READY));
endmodule : vrrb_bank_sva
bind vrrb_register_bank vrrb_bank_sva u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .ENABLE(ENABLE), .REQ(REQ), .RVALID(RVALID), .VCMD(VCMD), .ACK(ACK),
    .SLOW_RAMP_RATE(SLOW_RAMP_RATE), .READY(READY));
`default_nettype wire

// [vrrb_master_model.sv]
// Processor-side bus master driving the register bank
`timescale 1ns/1ps
`default_nettype none
module vrrb_master_model (
    // Clock
    input wire logic REF_CLK,
    // Requests
    output vrrb_pkg::vrrb_req_t REQ,
    output vrrb_pkg::vrrb_vcmd_t VCMD,
    // Answers
    input wire logic [7:0] RDATA,
    input wire logic RVALID,
    input wire vrrb_pkg::vrrb_ack_t ACK
);
    // Idle bus at time zero
    initial begin
        REQ = '0;
        VCMD = '0;
    end
    // Single read, answer taken the cycle after
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge REF_CLK);
        #2 REQ.rd = 1'b1;
        REQ.addr = a;
        @(posedge REF_CLK);
        #2 REQ.rd = 1'b0;
        d = RDATA;
        v = RVALID;
    endtask : reg_rd
    // Single write, no answer
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge REF_CLK);
        #2 REQ.wr = 1'b1;
        REQ.addr = a;
        REQ.wdata = w;
        @(posedge REF_CLK);
        #2 REQ.wr = 1'b0;
    endtask : reg_wr
    // Voltage-set command with its acknowledge
    task automatic vset(input logic [7:0] c, output vrrb_pkg::vrrb_ack_t k);
        @(posedge REF_CLK);
        #2 VCMD.valid = 1'b1;
        VCMD.code = c;
        @(posedge REF_CLK);
        #2 VCMD.valid = 1'b0;
        k = ACK;
    endtask : vset
endmodule : vrrb_master_model
`default_nettype wire

// [vrrb_testbench.sv]
// Self-checking testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic REF_CLK, RST_N, ENABLE, RVALID, OVERTEMPERATURE_ALERT, READY, v;
    logic [7:0] BOOT_CODE, PLATFORM_MAX_CURRENT, TEMPERATURE, RDATA, TARGET_CODE;
    logic [7:0] SLOW_RAMP_RATE, d;
    vrrb_pkg::vrrb_req_t REQ;
    vrrb_pkg::vrrb_vcmd_t VCMD;
    vrrb_pkg::vrrb_ack_t ACK, k;
    int fail_count = 0;
    int total_checks = 0;
    // Reset value table
    logic [7:0] ofs [16] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e,
        8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h47, 8'h50};
    logic [7:0] dflt [16] = '{8'h64, 8'h1e, 8'h0f, 8'h00, 8'h01, 8'h8c, 8'h55, 8'hca, 8'h00,
        8'hfb, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
    // Short ready wait keeps the run brief
    vrrb_register_bank #(.POWER_DOMAIN(1'b0), .TWO_PHASE(1'b1), .READY_CYCLES(10)) uut (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .ENABLE(ENABLE), .BOOT_CODE(BOOT_CODE),
        .PLATFORM_MAX_CURRENT(PLATFORM_MAX_CURRENT), .TEMPERATURE(TEMPERATURE), .REQ(REQ),
        .RDATA(RDATA), .RVALID(RVALID), .VCMD(VCMD), .ACK(ACK), .TARGET_CODE(TARGET_CODE),
        .SLOW_RAMP_RATE(SLOW_RAMP_RATE), .OVERTEMPERATURE_ALERT(OVERTEMPERATURE_ALERT),
        .READY(READY));
    vrrb_master_model host (.REF_CLK(REF_CLK), .REQ(REQ), .VCMD(VCMD), .RDATA(RDATA),
        .RVALID(RVALID), .ACK(ACK));
    // Verdict and end of run
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // Byte comparison
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Read with answer check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.reg_rd(a, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk($sformatf("reg %h", a), e, d);
    endtask : rd_chk
    // Let registered outputs settle
    task automatic settle();
        repeat (2) @(posedge REF_CLK);
        #2;
    endtask : settle
    // Reset values, early write and command refused
    task automatic t_defaults();
        foreach (ofs[i]) rd_chk(ofs[i], dflt[i]);
        host.reg_wr(8'h22, 8'h11);
        rd_chk(8'h22, 8'h64);
        host.vset(8'h40, k);
        chk("ack", 8'h02, {6'h00, k});
    endtask : t_defaults
    // Enable, ready wait, boot code and seeded limits
    task automatic t_startup();
        ENABLE = 1'b1;
        for (int i = 0; i < 40 && READY !== 1'b1; i++) @(posedge REF_CLK);
        #2 chk("ready", 8'h01, {7'h00, READY});
        rd_chk(8'h26, 8'h5a);
        chk("target", 8'h5a, TARGET_CODE);
        rd_chk(8'h43, 8'h32);
        rd_chk(8'h45, 8'h1e);
    endtask : t_startup
    // Alert level around the limit
    task automatic t_alert();
        TEMPERATURE = 8'h63;
        settle();
        chk("alert", 8'h00, {7'h00, OVERTEMPERATURE_ALERT});
        TEMPERATURE = 8'h64;
        settle();
        chk("alert", 8'h01, {7'h00, OVERTEMPERATURE_ALERT});
        host.reg_wr(8'h22, 8'h70);
        settle();
        chk("alert", 8'h00, {7'h00, OVERTEMPERATURE_ALERT});
        rd_chk(8'h22, 8'h70);
    endtask : t_alert
    // Every divisor code, then an illegal one
    task automatic t_selector();
        for (int i = 0; i < 4; i++) begin
            host.reg_wr(8'h2a, 8'h01 << i);
            rd_chk(8'h25, 8'h1e >> (i + 1));
            chk("slow rate", 8'h1e >> (i + 1), SLOW_RAMP_RATE);
        end
        host.reg_wr(8'h2a, 8'h03);
        rd_chk(8'h2a, 8'h08);
    endtask : t_selector
    // Read-only ignores writes, read/write keeps them
    task automatic t_access();
        host.reg_wr(8'h24, 8'h00);
        host.reg_wr(8'h2b, 8'h00);
        rd_chk(8'h24, 8'h1e);
        rd_chk(8'h2b, 8'h8c);
        host.reg_wr(8'h47, 8'h09);
        rd_chk(8'h47, 8'h09);
        host.reg_wr(8'h32, 8'h03);
        rd_chk(8'h32, 8'h03);
    endtask : t_access
    // Code limit, accepted code and margin both signs
    task automatic t_vset();
        host.reg_wr(8'h30, 8'h90);
        host.vset(8'h91, k);
        chk("ack", 8'h03, {6'h00, k});
        rd_chk(8'h31, 8'h00);
        host.vset(8'h90, k);
        chk("ack", 8'h01, {6'h00, k});
        rd_chk(8'h31, 8'h90);
        chk("target", 8'h90, TARGET_CODE);
        host.reg_wr(8'h33, 8'hff);
        settle();
        chk("target", 8'h8f, TARGET_CODE);
        host.reg_wr(8'h33, 8'h02);
        settle();
        chk("target", 8'h92, TARGET_CODE);
    endtask : t_vset
    // Clock
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // Watchdog
    initial begin
        #(5000 * 50);
        fail_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        RST_N = 1'b0;
        ENABLE = 1'b0;
        BOOT_CODE = 8'h5a;
        PLATFORM_MAX_CURRENT = 8'h64;
        TEMPERATURE = 8'h20;
        repeat (20) @(posedge REF_CLK);
        #2 RST_N = 1'b1;
        t_defaults();
        t_startup();
        t_alert();
        t_selector();
        t_access();
        t_vset();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
